// ===== core/hbsr_defs.vh
// Constants for the host bridge status and configuration register slice.
// Assumes the includer uses the names below; definitions only.
// Summary of operation
// - Parity error in address or data phase sets status bit 15, always.
// - Bits 15:12 and 8 clear only on write of one; zero leaves them.
// - Bit 14 sets whenever this bridge drives the system error signal.
// - Bit 13 sets on unexpected master abort; special cycle aborts excluded.
// - Bit 12 sets on received target abort; raises system error if enabled.
// - Select timing field bits 10:9 always reads 01b, read only.
// - Bit 8 sets when parity signal seen, we initiated, and reporting enabled.
// - Status register resets to 0290h.
// - Revision register is read only, returns fixed code, ignores writes.
// - Sub class code reads 00h, host bridge, read only.
// - Base class code reads 06h, bridge device, read only.
// - Latency count uses bits 7:3 with low three bits zero, in clocks.
// - On slice expiry, finish current data phase, release when grant drops.
// - Latency timer resets to 00h, which disables the slice limit.
// - Header type reads zero, writes ignored, no storage.
// - Parity reporting enable is command bit 6, gating bit 8 condition.
`ifndef HBSR_DEFS_VH
`define HBSR_DEFS_VH
`define HBSR_OFS_STATUS_LO   8'h06
`define HBSR_OFS_STATUS_HI   8'h07
`define HBSR_OFS_REVISION    8'h08
`define HBSR_OFS_SUBCLASS    8'h0A
`define HBSR_OFS_BASECLASS   8'h0B
`define HBSR_OFS_LATENCY     8'h0D
`define HBSR_OFS_HEADER      8'h0E
`define HBSR_BIT_PAR_ERR     15
`define HBSR_BIT_SYS_ERR     14
`define HBSR_BIT_MST_ABT     13
`define HBSR_BIT_TGT_ABT     12
`define HBSR_BIT_DAT_PAR     8
`define HBSR_STATUS_RESET    16'h0290
`define HBSR_STATUS_LO_FIXED 8'h90
`define HBSR_STATUS_W1C_MASK 16'hF100
`define HBSR_SELECT_TIMING   2'h1
`define HBSR_SUBCLASS_VAL    8'h00
`define HBSR_BASECLASS_VAL   8'h06
`define HBSR_HEADER_VAL      8'h00
`define HBSR_LATENCY_RESET   8'h00
`define HBSR_LATENCY_MASK    8'hF8
`define HBSR_REVISION_DEF    8'h5A
`endif

// ===== core/hbsr_w1c_flag.v
// One sticky error flag, set by hardware, cleared by writing one.
// Assumes set and clear come from logic on the same clock.
module hbsr_w1c_flag (
  input  wire i_sys_clk,
  input  wire i_sys_rst,
  input  wire i_set,
  input  wire i_clear,
  output reg  o_flag
);
  // Set wins over a clear in the same cycle so no event is lost
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      o_flag <= 1'b0;
    else if (i_set)
      o_flag <= 1'b1;
    else if (i_clear)
      o_flag <= 1'b0;
  end
endmodule

// ===== core/hbsr_slice_timer.v
// Master latency time slice counter for the bridge's own bus tenure.
// Assumes i_start pulses when the bridge begins as master.
module hbsr_slice_timer (
  input  wire       i_sys_clk,
  input  wire       i_sys_rst,
  input  wire [7:0] i_count,
  input  wire       i_start,
  input  wire       i_active,
  output reg        o_expired
);
  reg [7:0] remain;
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      remain    <= 8'h00;
      o_expired <= 1'b0;
    end else if (i_start) begin
      remain    <= i_count;
      o_expired <= 1'b0;
    end else if (!i_active) begin
      o_expired <= 1'b0;
    end else if (i_count == 8'h00) begin
      o_expired <= 1'b0;
    end else if (remain > 8'h01) begin
      remain <= remain - 8'h01;
    end else begin
      o_expired <= 1'b1;
    end
  end
endmodule

// ===== core/hbsr_top.v
// Status, identity and latency timer slice of the bridge config header.
// Assumes byte wide config access on the bus clock; error events are
// one-cycle pulses from the bridge's own bus logic on that clock.
`include "hbsr_defs.vh"
module hbsr_top #(
  // Value is arbitrary, stands in for the stepping code
  parameter [7:0] REVISION_CODE = `HBSR_REVISION_DEF
) (
  input  wire       i_sys_clk,
  input  wire       i_sys_rst,
  input  wire       i_cfg_rd,
  input  wire       i_cfg_wr,
  input  wire [7:0] i_cfg_addr,
  input  wire [7:0] i_cfg_wdata,
  output reg  [7:0] o_cfg_rdata,
  input  wire       i_parity_report_enable,
  input  wire       i_rta_serr_enable,
  input  wire       i_addr_parity_err,
  input  wire       i_data_parity_err,
  input  wire       i_serr_driven,
  input  wire       i_perr_seen,
  input  wire       i_we_initiated,
  input  wire       i_master_abort,
  input  wire       i_special_cycle,
  input  wire       i_target_abort,
  input  wire       i_tenure_start,
  input  wire       i_tenure_active,
  input  wire       i_data_phase_done,
  input  wire       i_grant,
  output reg        o_serr_request,
  output reg        o_release_bus,
  output reg  [7:0] o_latency_count,
  output reg  [15:0] o_pci_status
);

  ////////////////////////////////////////////////////////////////////////
  // Write decode; the low status byte holds no clearable bits
  wire wr_hi  = i_cfg_wr && (i_cfg_addr == `HBSR_OFS_STATUS_HI);
  wire wr_lat = i_cfg_wr && (i_cfg_addr == `HBSR_OFS_LATENCY);

  // Bit 8 lives in the high byte at offset 07h
  wire clr_par_err = wr_hi && i_cfg_wdata[`HBSR_BIT_PAR_ERR - 8];
  wire clr_sys_err = wr_hi && i_cfg_wdata[`HBSR_BIT_SYS_ERR - 8];
  wire clr_rma     = wr_hi && i_cfg_wdata[`HBSR_BIT_MST_ABT - 8];
  wire clr_rta     = wr_hi && i_cfg_wdata[`HBSR_BIT_TGT_ABT - 8];
  wire clr_dat_par = wr_hi && i_cfg_wdata[`HBSR_BIT_DAT_PAR - 8];

  ////////////////////////////////////////////////////////////////////////
  // Event conditions
  wire set_par_err = i_addr_parity_err || i_data_parity_err;
  wire set_rma     = i_master_abort && !i_special_cycle;
  wire set_rta     = i_target_abort;
  wire set_dat_par = i_perr_seen && i_we_initiated
                     && i_parity_report_enable;
  wire set_sys_err = i_serr_driven || o_serr_request;

  wire f_par_err;
  wire f_sys_err;
  wire f_rma;
  wire f_rta;
  wire f_dat_par;

  hbsr_w1c_flag u_par_err (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (set_par_err),
    .i_clear   (clr_par_err),
    .o_flag    (f_par_err)
  );
  hbsr_w1c_flag u_sys_err (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (set_sys_err),
    .i_clear   (clr_sys_err),
    .o_flag    (f_sys_err)
  );
  hbsr_w1c_flag u_rma (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (set_rma),
    .i_clear   (clr_rma),
    .o_flag    (f_rma)
  );
  hbsr_w1c_flag u_rta (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (set_rta),
    .i_clear   (clr_rta),
    .o_flag    (f_rta)
  );
  hbsr_w1c_flag u_dat_par (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_set     (set_dat_par),
    .i_clear   (clr_dat_par),
    .o_flag    (f_dat_par)
  );

  // Timing field is hardwired; bit 11 reads zero, and the reserved low
  // byte keeps the fixed pattern of the reset value so reads match it
  wire [15:0] status_now = {f_par_err, f_sys_err, f_rma, f_rta, 1'b0,
                            `HBSR_SELECT_TIMING, f_dat_par,
                            `HBSR_STATUS_LO_FIXED};

  ////////////////////////////////////////////////////////////////////////
  // Latency timer, only bits 7:3 are stored
  localparam [7:0] LAT_RESET = `HBSR_LATENCY_RESET;
  reg [4:0] latency_hi;
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      latency_hi <= LAT_RESET[7:3];
    else if (wr_lat)
      latency_hi <= i_cfg_wdata[7:3];
  end
  wire [7:0] latency_val = {latency_hi, 3'h0};

  wire slice_expired;
  hbsr_slice_timer u_slice (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_count   (latency_val),
    .i_start   (i_tenure_start),
    .i_active  (i_tenure_active),
    .o_expired (slice_expired)
  );

  // Release: slice spent, current data phase done, and grant removed
  reg phase_done_seen;
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_done_seen <= 1'b0;
      o_release_bus   <= 1'b0;
    end else begin
      if (!i_tenure_active || !slice_expired)
        phase_done_seen <= 1'b0;
      else if (i_data_phase_done)
        phase_done_seen <= 1'b1;
      o_release_bus <= i_tenure_active && slice_expired && !i_grant
                       && (phase_done_seen || i_data_phase_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pci_status    <= `HBSR_STATUS_RESET;
      o_latency_count <= `HBSR_LATENCY_RESET;
      o_serr_request  <= 1'b0;
    end else begin
      o_pci_status    <= status_now;
      o_latency_count <= latency_val;
      o_serr_request  <= set_rta && i_rta_serr_enable;
    end
  end

  // Read data: one cycle after the read strobe; unmapped reads zero
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg_rdata <= 8'h00;
    end else if (i_cfg_rd) begin
      case (i_cfg_addr)
        `HBSR_OFS_STATUS_LO: o_cfg_rdata <= status_now[7:0];
        `HBSR_OFS_STATUS_HI: o_cfg_rdata <= status_now[15:8];
        `HBSR_OFS_REVISION:  o_cfg_rdata <= REVISION_CODE;
        `HBSR_OFS_SUBCLASS:  o_cfg_rdata <= `HBSR_SUBCLASS_VAL;
        `HBSR_OFS_BASECLASS: o_cfg_rdata <= `HBSR_BASECLASS_VAL;
        `HBSR_OFS_LATENCY:   o_cfg_rdata <= latency_val;
        `HBSR_OFS_HEADER:    o_cfg_rdata <= `HBSR_HEADER_VAL;
        default:             o_cfg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// ===== dv/hbsr_assertions.sv
// Port checker for hbsr_top.
// Assumes one clock domain; bound at the foot.
module hbsr_chk (
  input wire        i_sys_clk, i_sys_rst, i_cfg_wr, i_grant,
  input wire        i_addr_parity_err, i_data_parity_err,
  input wire        i_serr_driven, i_master_abort, i_special_cycle,
  input wire        i_target_abort, i_rta_serr_enable, i_perr_seen,
  input wire        i_we_initiated, i_parity_report_enable,
  input wire        o_serr_request, o_release_bus,
  input wire  [7:0] i_cfg_addr, i_cfg_wdata, o_latency_count,
  input wire [15:0] o_pci_status
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_ta;
    i_target_abort && i_rta_serr_enable;
  endsequence
  sequence s_ta_seen;
    o_serr_request ##1 o_pci_status[12];
  endsequence
  property p_par_err; i_addr_parity_err || i_data_parity_err
    |-> ##2 o_pci_status[15]; endproperty
  a_par_err: assert property (p_par_err) else $error("parity flag");
  property p_sys_err; i_serr_driven |-> ##2 o_pci_status[14]; endproperty
  a_sys_err: assert property (p_sys_err) else $error("serr flag");
  property p_rma; $rose(o_pci_status[13])
    |-> $past(i_master_abort && !i_special_cycle, 2); endproperty
  a_rma: assert property (p_rma) else $error("bad abort flag");
  property p_rta; s_ta |=> s_ta_seen; endproperty
  a_rta: assert property (p_rta) else $error("target abort");
  property p_fix; o_pci_status[11:9] == 3'h1; endproperty
  a_fix: assert property (p_fix) else $error("timing field");
  property p_dat_par; $rose(o_pci_status[8]) |-> $past(i_perr_seen
    && i_we_initiated && i_parity_report_enable, 2); endproperty
  a_dat_par: assert property (p_dat_par) else $error("bad parity flag");
  property p_w1c; i_cfg_wr && i_cfg_addr == 8'h07 && i_cfg_wdata[7]
    && !i_addr_parity_err && !i_data_parity_err
    |-> ##2 !o_pci_status[15]; endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_lat; i_cfg_wr && i_cfg_addr == 8'h0D
    |-> ##2 o_latency_count == ($past(i_cfg_wdata, 2) & 8'hF8); endproperty
  a_lat: assert property (p_lat) else $error("latency count");
  property p_rel; $rose(o_release_bus) |-> $past(!i_grant); endproperty
  a_rel: assert property (p_rel) else $error("early release");
endmodule
bind hbsr_top hbsr_chk chk_u (.*);

// ===== dv/hbsr_arb_model.sv
// Arbiter and bus side of the bridge's master tenure.
// Assumes i_go is a one-cycle request from the bench.
module hbsr_arb_model (
  input  wire       i_sys_clk, i_sys_rst, i_go, i_release,
  input  wire [7:0] i_drop_at,
  output logic      o_start, o_active, o_done, o_grant
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] n;
  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {o_start, o_active, o_done, o_grant, n} <= 12'h000;
    end else begin
      o_start <= i_go;
      // Data phases end every other clock, so release waits on one
      o_done <= o_active && !o_done;
      if (i_go) begin
        {o_active, o_grant, n} <= 10'h300;
      end else if (o_active) begin
        n <= n + 8'h01;
        if (n == i_drop_at) o_grant <= 1'b0;
        if (i_release) o_active <= 1'b0;
      end
    end
  end
endmodule

// ===== dv/tb.sv
// Self-checking bench for hbsr_top.
// Assumes the arbiter model drives the tenure inputs.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] REV = 8'hC3; // Arbitrary revision value
  logic i_sys_clk = 0, i_sys_rst = 1, rd = 0, wr = 0, go = 0;
  logic [7:0] addr = 0, wd = 0, drop = 0, o_cfg_rdata, lat;
  logic [9:0] ev = 0;
  logic [15:0] sts;
  logic st, act, dn, gnt, rel, sreq;
  int n_errors = 0, checked = 0, cyc = 0, c;
  logic [23:0] regs [8] = '{24'h069090, 24'h070202, {8'h08, REV, REV},
    24'h0A0000, 24'h0B0606, 24'h0D00F8, 24'h0E0000, 24'h300000};
  logic [17:0] evt [10] = '{{10'h001, 8'h82}, {10'h002, 8'h82},
    {10'h004, 8'h42}, {10'h008, 8'h22}, {10'h048, 8'h02},
    {10'h010, 8'h12}, {10'h210, 8'h52}, {10'h1A0, 8'h03},
    {10'h0A0, 8'h02}, {10'h120, 8'h02}};
  hbsr_top #(.REVISION_CODE(REV)) dut_u (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_cfg_rd(rd), .i_cfg_wr(wr),
    .i_cfg_addr(addr), .i_cfg_wdata(wd), .o_cfg_rdata(o_cfg_rdata),
    .i_addr_parity_err(ev[0]), .i_data_parity_err(ev[1]),
    .i_serr_driven(ev[2]), .i_master_abort(ev[3]),
    .i_target_abort(ev[4]), .i_perr_seen(ev[5]),
    .i_special_cycle(ev[6]), .i_we_initiated(ev[7]),
    .i_parity_report_enable(ev[8]), .i_rta_serr_enable(ev[9]),
    .i_tenure_start(st), .i_tenure_active(act), .i_data_phase_done(dn),
    .i_grant(gnt), .o_serr_request(sreq), .o_release_bus(rel),
    .o_latency_count(lat), .o_pci_status(sts));
  hbsr_arb_model arb_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_go(go), .i_release(rel), .i_drop_at(drop), .o_start(st),
    .o_active(act), .o_done(dn), .o_grant(gnt));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out;
    end
  end
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_b(logic [7:0] a, logic [7:0] d);
    @(posedge i_sys_clk) #1 {addr, wd, wr} = {a, d, 1'b1};
    @(posedge i_sys_clk) #1 wr = 0;
  endtask
  task automatic rd_b(logic [7:0] a, logic [7:0] e);
    @(posedge i_sys_clk) #1 {addr, rd} = {a, 1'b1};
    @(posedge i_sys_clk) #1 rd = 0;
    cmp("rdata", e, o_cfg_rdata);
  endtask
  // Tenure from go to release; slack covers the registered stages
  task automatic ten(logic [7:0] d, int lo, int hi);
    drop = d;
    @(posedge i_sys_clk) #1 go = 1;
    @(posedge i_sys_clk) #1 go = 0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    for (c = 3; !rel && c < 99; c++) @(posedge i_sys_clk) #1;
    cmp("tenure", 8'h01, 8'(c >= lo && c <= hi));
  endtask
  task automatic close_out;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_sys_clk);
    cmp("status_hi", 8'h02, sts[15:8]);
    cmp("status_lo", 8'h90, sts[7:0]);
    repeat (5) @(posedge i_sys_clk);
    #1 i_sys_rst = 0;
    foreach (regs[i]) begin
      rd_b(regs[i][23:16], regs[i][15:8]);
      wr_b(regs[i][23:16], 8'hFF);
      rd_b(regs[i][23:16], regs[i][7:0]);
    end
    foreach (evt[i]) begin
      @(posedge i_sys_clk) #1 ev = evt[i][17:8];
      @(posedge i_sys_clk) #1 ev = 0;
      rd_b(8'h07, evt[i][7:0]);
      cmp("status", evt[i][7:0], sts[15:8]);
      wr_b(8'h07, 8'h00);
      rd_b(8'h07, evt[i][7:0]);
      wr_b(8'h07, 8'hFF);
      rd_b(8'h07, 8'h02);
    end
    wr_b(8'h0D, 8'h1F);
    @(posedge i_sys_clk) #1 cmp("latency", 8'h18, lat);
    ten(8'h04, 20, 34);
    ten(8'h32, 49, 58);
    wr_b(8'h0D, 8'h07);
    ten(8'h04, 99, 99);
    // Event and clear in one cycle: the hardware set must win
    @(posedge i_sys_clk) #1 {ev, addr, wd} = {10'h002, 8'h07, 8'h80};
    wr = 1;
    @(posedge i_sys_clk) #1 {ev, wr} = 0;
    rd_b(8'h07, 8'h82);
    // Target abort with enable: request stands one cycle only
    @(posedge i_sys_clk) #1 ev = 10'h210;
    @(posedge i_sys_clk) #1 ev = 0;
    cmp("serr_request", 8'h01, {7'h00, sreq});
    @(posedge i_sys_clk) #1 cmp("serr_request", 8'h00, {7'h00, sreq});
    rd_b(8'h07, 8'hD2);
    // Reset in mid-run drops flags and latency back to defaults
    wr_b(8'h0D, 8'h1F);
    @(posedge i_sys_clk) #1 i_sys_rst = 1;
    @(posedge i_sys_clk) #1 i_sys_rst = 0;
    cmp("status_hi", 8'h02, sts[15:8]);
    cmp("status_lo", 8'h90, sts[7:0]);
    cmp("latency", 8'h00, lat);
    rd_b(8'h07, 8'h02);
    rd_b(8'h0D, 8'h00);
    close_out;
  end
endmodule
